// ### bench/cpu_core_model.sv
`timescale 1ns/1ns
module cpu_core_model
  import irq_regs_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // request from the block
  input  wire cpu_req_type cpu_req_i,
  input  wire logic        en_i,
  // exception processing done
  output logic             ack_o,
  output logic [4:0]       ack_source_o
);
  logic req_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_reg      <= 1'b0;
      ack_o        <= 1'b0;
      ack_source_o <= 5'h00;
    end else begin
      // one ack per accepted request, as a core enters its handler once
      req_reg      <= cpu_req_i.req;
      ack_o        <= en_i && cpu_req_i.req && !req_reg;
      ack_source_o <= cpu_req_i.source;
    end
  end
endmodule : cpu_core_model

// ### bench/test_irq_priority_and_sense_regs.sv
`timescale 1ns/1ns
module test_irq_priority_and_sense_regs;
  import irq_regs_pkg::*;
  logic        clk, rst_n, mrst, nmi, en, wd, bus_state_ctrl, ack;
  logic [7:0]  pin_n, xdone;
  logic [22:0] preq;
  logic [3:0]  mask;
  logic [4:0]  asrc;
  logic [15:0] rdata;
  reg_bus_type bus;
  cpu_req_type req;
  logic        nev, out_n;
  int          failures, samples_checked;
  irq_priority_and_sense_regs irq_priority_and_sense_regs_i (
    .ref_clk_i(clk), .rst_n_i(rst_n), .manual_reset_i(mrst),
    .bus_i(bus), .rdata_o(rdata), .nmi_pin_i(nmi), .irq_pin_n_i(pin_n),
    .periph_req_i(preq), .watchdog_source_i(wd), .bus_state_ctrl_i(bus_state_ctrl),
    .cpu_mask_level_i(mask), .cpu_ack_i(ack), .cpu_ack_source_i(asrc),
    .xfer_done_i(xdone), .cpu_req_o(req), .nmi_event_o(nev),
    .request_out_pin_n_o(out_n));
  cpu_core_model cpu_core_model_i (.ref_clk_i(clk), .rst_n_i(rst_n),
    .cpu_req_i(req), .en_i(en), .ack_o(ack), .ack_source_o(asrc));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk) {bus.wr, bus.addr, bus.wdata} <= {1'b1, a, d};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk) {bus.rd, bus.addr} <= {1'b1, a};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic give_verdict;
    $display("mismatches %0d of %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #50000 failures++;
    give_verdict();
  end
  initial begin
    {rst_n, mrst, en, wd, bus_state_ctrl, xdone, preq} = '0;
    {nmi, pin_n, mask, bus} = {1'b1, 8'hFF, 4'hF, 22'h0};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(8, 16'h8000);
    rd(9, 16'h0000);
    rd(12, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      wr(i[3:0], 16'hA5C3 ^ 16'(i));
      rd(i[3:0], 16'hA5C3 ^ 16'(i));
    end
    wr(8, 16'hFFFF);
    rd(8, 16'h81FF);
    nmi <= 1'b0;
    rd(8, 16'h01FF);
    nmi <= 1'b1;
    tick(1);
    chk("nmi_event", 16'h0001, {15'h0, nev});
    tick(1);
    chk("nmi_event", 16'h0000, {15'h0, nev});
    wr(0, 16'h7000);
    pin_n <= 8'hFE;
    tick(2);
    pin_n <= 8'hFF;
    rd(9, 16'h0080);
    wr(9, 16'h0080);
    wr(9, 16'h0000);
    rd(9, 16'h0080);
    wr(9, 16'h0000);
    rd(9, 16'h0000);
    pin_n <= 8'hFD;
    tick(2);
    {pin_n, xdone} <= {8'hFF, 8'h02};
    tick(1);
    xdone <= 8'h00;
    rd(9, 16'h0000);
    {mask, en, pin_n} <= {4'h3, 1'b1, 8'hFE};
    tick(3);
    chk("req", 16'h02E0, {6'h0, req});
    chk("out_n", 16'h0000, {15'h0, out_n});
    pin_n <= 8'hFF;
    tick(4);
    rd(9, 16'h0000);
    en <= 1'b0;
    wr(2, 16'h5500);
    preq <= 23'h000003;
    tick(2);
    chk("req", 16'h02A8, {6'h0, req});
    wr(7, 16'h9000);
    wd <= 1'b1;
    tick(2);
    chk("req", 16'h033C, {6'h0, req});
    {wd, bus_state_ctrl, mask} <= {1'b0, 1'b1, 4'h9};
    tick(2);
    chk("out_n", 16'h0001, {15'h0, out_n});
    wr(8, 16'h0000);
    {nmi, pin_n} <= {1'b0, 8'hDF};
    tick(1);
    chk("nmi_event", 16'h0001, {15'h0, nev});
    tick(2);
    rd(9, 16'h0004);
    wr(8, 16'h0080);
    pin_n <= 8'h7E;
    tick(2);
    mrst <= 1'b1;
    tick(1);
    mrst <= 1'b0;
    rd(0, 16'h0000);
    rd(8, 16'h0080);
    rd(9, 16'h0001);
    give_verdict();
  end
endmodule : test_irq_priority_and_sense_regs

// ### hw/irq_priority_and_sense_regs.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
module irq_priority_and_sense_regs (
  // clock and resets
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       manual_reset_i,
  // register port
  input  wire irq_regs_pkg::reg_bus_type  bus_i,
  output logic [15:0]                     rdata_o,
  // request sources
  input  wire logic                       nmi_pin_i,
  input  wire logic [7:0]                 irq_pin_n_i,
  input  wire logic [22:0]                periph_req_i,
  input  wire logic                       watchdog_source_i,
  input  wire logic                       bus_state_ctrl_i,
  // cpu side
  input  wire logic [3:0]                 cpu_mask_level_i,
  input  wire logic                       cpu_ack_i,
  input  wire logic [4:0]                 cpu_ack_source_i,
  input  wire logic [7:0]                 xfer_done_i,
  output irq_regs_pkg::cpu_req_type       cpu_req_o,
  output logic                            nmi_event_o,
  output logic                            request_out_pin_n_o
);
  import irq_regs_pkg::*;

  localparam irq_state_type STATE_RESET = '{
    prio:         {8{PRIO_RESET}},
    nmi_edge_sel: 1'b0,
    pin_edge:     SENSE_RESET,
    flags:        FLAGS_RESET,
    armed:        8'h00,
    pin_prev:     8'hFF,
    nmi_prev:     1'b0,
    primed:       1'b0,
    nmi_evt:      1'b0,
    rdata:        16'h0000,
    cpu:          '0,
    out_n:        1'b1
  };

  irq_state_type state_reg;
  irq_state_type state_next;

  logic [NUM_FIELDS-1:0] req_vec;
  logic [3:0]            best_level;
  logic [4:0]            best_src;
  logic                  best_found;

  // request vector: field index is also default rank, lower wins ties
  always_comb begin
    req_vec[7:0]  = state_reg.flags;
    req_vec[27:8] = periph_req_i[PERIPH_SPLIT-1:0];
    req_vec[SHARED_FIELD] = watchdog_source_i | bus_state_ctrl_i;
    req_vec[31:29] = periph_req_i[NUM_PERIPH-1:PERIPH_SPLIT];
  end

  always_comb begin
    logic [3:0] lvl;
    lvl        = 4'h0;
    best_level = 4'h0;
    best_src   = 5'h00;
    best_found = 1'b0;
    for (int f = 0; f < NUM_FIELDS; f++) begin
      // field f sits in register f/4, upper nibble first
      lvl = state_reg.prio[f/4][(12 - 4*(f%4)) +: 4];
      // larger code means higher level; strict compare keeps rank
      if (req_vec[f] && (!best_found || lvl > best_level)) begin
        best_level = lvl;
        best_src   = 5'(f);
        best_found = 1'b1;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.pin_prev = irq_pin_n_i;
    state_next.nmi_prev = nmi_pin_i;
    state_next.primed   = 1'b1;
    state_next.rdata    = 16'h0000;
    // first cycle after reset has no valid history, so no edge then
    state_next.nmi_evt = state_reg.primed &&
      (state_reg.nmi_edge_sel ? (!state_reg.nmi_prev && nmi_pin_i)
                              : (state_reg.nmi_prev && !nmi_pin_i));

    // register writes
    if (bus_i.wr) begin
      if (bus_i.addr <= PRIO_LAST_OFS) begin
        state_next.prio[bus_i.addr[2:0]] = bus_i.wdata;
      end else if (bus_i.addr == SENSE_CTRL_OFS) begin
        // bit 15 and bits 14-9 have no storage
        state_next.nmi_edge_sel = bus_i.wdata[NMI_EDGE_BIT];
        for (int i = 0; i < NUM_PINS; i++) begin
          state_next.pin_edge[i] = bus_i.wdata[7-i];
        end
      end else if (bus_i.addr == REQ_FLAGS_OFS) begin
        for (int i = 0; i < NUM_PINS; i++) begin
          // only a zero after a read of one withdraws
          if (state_reg.pin_edge[i] && state_reg.armed[i] &&
              !bus_i.wdata[7-i]) begin
            state_next.flags[i] = 1'b0;
          end
          state_next.armed[i] = 1'b0;
        end
      end
    end

    // register reads, data stands one cycle only
    if (bus_i.rd) begin
      if (bus_i.addr <= PRIO_LAST_OFS) begin
        state_next.rdata = state_reg.prio[bus_i.addr[2:0]];
      end else if (bus_i.addr == SENSE_CTRL_OFS) begin
        state_next.rdata[NMI_LEVEL_BIT] = nmi_pin_i;
        state_next.rdata[NMI_EDGE_BIT]  = state_reg.nmi_edge_sel;
        for (int i = 0; i < NUM_PINS; i++) begin
          state_next.rdata[7-i] = state_reg.pin_edge[i];
        end
      end else if (bus_i.addr == REQ_FLAGS_OFS) begin
        for (int i = 0; i < NUM_PINS; i++) begin
          state_next.rdata[7-i] = state_reg.flags[i];
          if (state_reg.flags[i]) begin
            state_next.armed[i] = 1'b1;
          end
        end
      end
    end

    for (int i = 0; i < NUM_PINS; i++) begin
      if (state_reg.pin_edge[i]) begin
        if (cpu_ack_i && cpu_ack_source_i == 5'(i)) begin
          state_next.flags[i] = 1'b0;
        end
        if (xfer_done_i[i]) begin
          state_next.flags[i] = 1'b0;
        end
        // set after the clears so a coincident edge is kept
        if (state_reg.primed && state_reg.pin_prev[i] &&
            !irq_pin_n_i[i]) begin
          state_next.flags[i] = 1'b1;
        end
      end else begin
        state_next.flags[i] = !irq_pin_n_i[i];
      end
    end

    // manual reset spares sense control and level flags
    if (manual_reset_i) begin
      state_next.prio = {8{PRIO_RESET}};
      state_next.flags = state_next.flags & ~state_reg.pin_edge;
      state_next.armed = 8'h00;
    end

    state_next.cpu.req    = best_found &&
                            (best_level > cpu_mask_level_i);
    state_next.cpu.level  = best_level;
    state_next.cpu.source = best_src;
    state_next.out_n      = !state_next.cpu.req;
  end

  // power-on reset clears everything but pin_prev and out_n, which load high
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o             = state_reg.rdata;
  assign cpu_req_o           = state_reg.cpu;
  assign nmi_event_o         = state_reg.nmi_evt;
  assign request_out_pin_n_o = state_reg.out_n;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_prio_manual_clear: assert property (
    manual_reset_i |=> state_reg.prio == '0)
    else $error("priority registers not cleared by manual reset");

  chk_nmi_level_read: assert property (
    bus_i.rd && bus_i.addr == SENSE_CTRL_OFS
      |=> rdata_o[NMI_LEVEL_BIT] == $past(nmi_pin_i))
    else $error("pin level bit does not show the pin");

  chk_ctrl_reserved_zero: assert property (
    bus_i.rd && bus_i.addr == SENSE_CTRL_OFS |=> rdata_o[14:9] == '0)
    else $error("reserved control bits not zero");

  chk_flags_reserved_zero: assert property (
    bus_i.rd && bus_i.addr == REQ_FLAGS_OFS |=> rdata_o[15:8] == '0)
    else $error("reserved flag bits not zero");

  chk_level_flag_follow: assert property (
    !state_reg.pin_edge[0] && !manual_reset_i
      |=> state_reg.flags[0] == !$past(irq_pin_n_i[0]))
    else $error("level flag does not follow pin");

  chk_edge_flag_set: assert property (
    state_reg.pin_edge[0] && state_reg.primed && state_reg.pin_prev[0]
      && !irq_pin_n_i[0] && !manual_reset_i |=> state_reg.flags[0])
    else $error("falling edge did not set flag");

  chk_mask_compare: assert property (
    cpu_req_o.req |-> cpu_req_o.level > $past(cpu_mask_level_i))
    else $error("request forwarded at or below mask");

  chk_out_pin_mirror: assert property (
    request_out_pin_n_o == !cpu_req_o.req)
    else $error("request pin does not mirror request");

  chk_nmi_rise_detect: assert property (
    state_reg.primed && state_reg.nmi_edge_sel && !state_reg.nmi_prev
      && nmi_pin_i |=> nmi_event_o)
    else $error("rising nonmaskable edge missed");

  chk_prio_write_take: assert property (
    bus_i.wr && bus_i.addr <= PRIO_LAST_OFS && !manual_reset_i
      |=> state_reg.prio[$past(bus_i.addr[2:0])] == $past(bus_i.wdata))
    else $error("priority write not stored");

  chk_prio_read_data: assert property (
    bus_i.rd && bus_i.addr == 4'h0
      |=> rdata_o == $past(state_reg.prio[0]))
    else $error("priority read data wrong");

  chk_rdata_idle_zero: assert property (
    !bus_i.rd |=> rdata_o == '0)
    else $error("read data not zero outside a read");

  chk_unmapped_read_zero: assert property (
    bus_i.rd && bus_i.addr > REQ_FLAGS_OFS |=> rdata_o == '0)
    else $error("unmapped read not zero");

  chk_sense_write_pin0: assert property (
    bus_i.wr && bus_i.addr == SENSE_CTRL_OFS
      |=> state_reg.pin_edge[0] == $past(bus_i.wdata[7]))
    else $error("pin 0 sense select not stored");

  chk_sense_write_pin7: assert property (
    bus_i.wr && bus_i.addr == SENSE_CTRL_OFS
      |=> state_reg.pin_edge[7] == $past(bus_i.wdata[0]))
    else $error("pin 7 sense select not stored");

  chk_edge_sel_write: assert property (
    bus_i.wr && bus_i.addr == SENSE_CTRL_OFS
      |=> state_reg.nmi_edge_sel == $past(bus_i.wdata[NMI_EDGE_BIT]))
    else $error("edge select not stored");

  chk_sense_read_pin0: assert property (
    bus_i.rd && bus_i.addr == SENSE_CTRL_OFS
      |=> rdata_o[7] == $past(state_reg.pin_edge[0]))
    else $error("pin 0 sense select read wrong");

  chk_edge_sel_read: assert property (
    bus_i.rd && bus_i.addr == SENSE_CTRL_OFS
      |=> rdata_o[NMI_EDGE_BIT] == $past(state_reg.nmi_edge_sel))
    else $error("edge select read wrong");

  chk_sense_kept_mreset: assert property (
    manual_reset_i && !bus_i.wr |=> $stable(state_reg.pin_edge))
    else $error("sense control lost on manual reset");

  chk_nmi_fall_detect: assert property (
    state_reg.primed && !state_reg.nmi_edge_sel && state_reg.nmi_prev
      && !nmi_pin_i |=> nmi_event_o)
    else $error("falling nonmaskable edge missed");

  chk_nmi_no_false: assert property (
    !state_reg.primed |=> !nmi_event_o)
    else $error("false nonmaskable edge after reset");

  chk_flag_read_pin0: assert property (
    bus_i.rd && bus_i.addr == REQ_FLAGS_OFS
      |=> rdata_o[7] == $past(state_reg.flags[0]))
    else $error("pin 0 flag read in wrong bit");

  chk_flag_read_pin7: assert property (
    bus_i.rd && bus_i.addr == REQ_FLAGS_OFS
      |=> rdata_o[0] == $past(state_reg.flags[7]))
    else $error("pin 7 flag read in wrong bit");

  chk_level_flag_clear: assert property (
    !state_reg.pin_edge[0] && irq_pin_n_i[0] |=> !state_reg.flags[0])
    else $error("level flag set while pin high");

  chk_level_set_pin7: assert property (
    !state_reg.pin_edge[7] && !irq_pin_n_i[7] |=> state_reg.flags[7])
    else $error("level flag clear while pin low");

  chk_edge_flag_hold: assert property (
    state_reg.pin_edge[0] && state_reg.flags[0] && !xfer_done_i[0]
      && !cpu_ack_i && !manual_reset_i && !bus_i.wr |=> state_reg.flags[0])
    else $error("held edge flag lost");

  chk_withdraw_clear: assert property (
    state_reg.pin_edge[0] && state_reg.armed[0] && bus_i.wr
      && bus_i.addr == REQ_FLAGS_OFS && !bus_i.wdata[7]
      && !(state_reg.primed && state_reg.pin_prev[0] && !irq_pin_n_i[0])
      |=> !state_reg.flags[0])
    else $error("withdraw did not clear flag");

  chk_withdraw_needs_arm: assert property (
    state_reg.pin_edge[0] && state_reg.flags[0] && bus_i.wr
      && bus_i.addr == REQ_FLAGS_OFS
      && (!state_reg.armed[0] || bus_i.wdata[7])
      && !cpu_ack_i && !xfer_done_i[0] && !manual_reset_i
      |=> state_reg.flags[0])
    else $error("flag cleared without armed zero write");

  chk_ack_clear: assert property (
    state_reg.pin_edge[0] && cpu_ack_i && cpu_ack_source_i == 5'h00
      && !(state_reg.primed && state_reg.pin_prev[0] && !irq_pin_n_i[0])
      |=> !state_reg.flags[0])
    else $error("exception done did not clear flag");

  chk_xfer_clear: assert property (
    state_reg.pin_edge[0] && xfer_done_i[0]
      && !(state_reg.primed && state_reg.pin_prev[0] && !irq_pin_n_i[0])
      |=> !state_reg.flags[0])
    else $error("transfer done did not clear flag");

  chk_manual_drop_edge: assert property (
    manual_reset_i && state_reg.pin_edge[0] |=> !state_reg.flags[0])
    else $error("pending edge kept through manual reset");

  chk_arm_on_read: assert property (
    bus_i.rd && bus_i.addr == REQ_FLAGS_OFS && state_reg.flags[0]
      && !manual_reset_i |=> state_reg.armed[0])
    else $error("read of one did not arm withdraw");

  chk_arm_consumed: assert property (
    bus_i.wr && bus_i.addr == REQ_FLAGS_OFS |=> !state_reg.armed[0])
    else $error("withdraw arm not consumed by write");

  chk_mask_refuse: assert property (
    best_found && best_level <= cpu_mask_level_i |=> !cpu_req_o.req)
    else $error("request at or below mask forwarded");

  chk_forward_above: assert property (
    best_found && best_level > cpu_mask_level_i |=> cpu_req_o.req)
    else $error("request above mask not forwarded");

  chk_tie_low_index: assert property (
    req_vec[0] && req_vec[1]
      && state_reg.prio[0][15:12] == state_reg.prio[0][11:8]
      |=> cpu_req_o.source != 5'h01)
    else $error("tie not given to lower index");

  chk_level_order: assert property (
    req_vec[8] && req_vec[9]
      && state_reg.prio[2][15:12] < state_reg.prio[2][11:8]
      |=> cpu_req_o.source != 5'h08)
    else $error("lower level beat higher level");

  chk_shared_level: assert property (
    cpu_req_o.req && cpu_req_o.source == 5'(SHARED_FIELD)
      |-> cpu_req_o.level == $past(state_reg.prio[7][15:12]))
    else $error("shared field level wrong");

  chk_shared_either: assert property (
    bus_state_ctrl_i && state_reg.prio[7][15:12] > cpu_mask_level_i
      |=> cpu_req_o.req)
    else $error("bus controller source not served");

  chk_prio_kept_idle: assert property (
    !manual_reset_i && !bus_i.wr |=> $stable(state_reg.prio))
    else $error("priority registers changed without write");

  chk_out_low_on_req: assert property (
    $rose(cpu_req_o.req) |-> !request_out_pin_n_o)
    else $error("request pin not low on new request");

endmodule : irq_priority_and_sense_regs

// ### hw/irq_regs_pkg.sv
package irq_regs_pkg;

  localparam int NUM_PINS     = 8;
  localparam int NUM_FIELDS   = 32;
  localparam int NUM_PERIPH   = 23;
  localparam int SHARED_FIELD = 28;
  localparam int PERIPH_SPLIT = 20;

  localparam logic [3:0] PRIO_LAST_OFS  = 4'h7;
  localparam logic [3:0] SENSE_CTRL_OFS = 4'h8;
  localparam logic [3:0] REQ_FLAGS_OFS  = 4'h9;

  localparam int NMI_LEVEL_BIT = 15;
  localparam int NMI_EDGE_BIT  = 8;

  localparam logic [15:0] PRIO_RESET  = 16'h0000;
  localparam logic [7:0]  SENSE_RESET = 8'h00;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_bus_type;

  typedef struct packed {
    logic       req;
    logic [3:0] level;
    logic [4:0] source;
  } cpu_req_type;

  typedef struct packed {
    logic [7:0][15:0] prio;
    logic             nmi_edge_sel;
    logic [7:0]       pin_edge;
    logic [7:0]       flags;
    logic [7:0]       armed;
    logic [7:0]       pin_prev;
    logic             nmi_prev;
    logic             primed;
    logic             nmi_evt;
    logic [15:0]      rdata;
    cpu_req_type      cpu;
    logic             out_n;
  } irq_state_type;

endpackage : irq_regs_pkg
